/* File: rtl/spw_pkt_pkg.sv */
// Constants shared by the channel packet datapath.
// Assumes a 250 MHz system clock and a byte-wide link codec beside it.
package spw_pkt_pkg;

  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] MASK_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] EVENT_ADDR = 8'h0C;
  localparam logic [7:0] TX_DATA_ADDR = 8'h10;
  localparam logic [7:0] TX_LEN_ADDR = 8'h14;
  localparam logic [7:0] RX_DATA_ADDR = 8'h18;
  localparam logic [7:0] RX_LEN_ADDR = 8'h1C;
  localparam logic [7:0] REGION_ADDR = 8'h20;

  // Control register fields
  localparam int CTRL_DIV_LSB = 0;
  localparam int CTRL_TEST_BIT = 8;
  localparam int CTRL_PKTDIS_BIT = 9;
  localparam int CTRL_MASTER_BIT = 10;
  localparam logic [7:0] CTRL_DIV_RESET = 8'h19;

  // Event bit positions, shared by mask and sticky event register
  localparam int EV_TX_AEMPTY = 0;
  localparam int EV_RX_AFULL = 1;
  localparam int EV_PKT_SENT = 2;
  localparam int EV_PKT_RCVD = 3;
  localparam int EV_TIMECODE = 4;
  localparam int EV_ERROR = 5;
  localparam int EV_COUNT = 6;

  // Almost-empty / almost-full margin in words
  localparam int ALMOST_MARGIN = 16;

  // Flow control: one token grants eight characters, seven at most
  localparam logic [2:0] MAX_TOKENS = 3'h7;
  localparam int BYTES_PER_TOKEN = 8;

  // Bit rate while the link is being established
  localparam int CLK_HZ = 250_000_000;
  localparam int CONNECT_BPS = 10_000_000;
  localparam logic [7:0] CONNECT_DIV = 8'(CLK_HZ / CONNECT_BPS);

  // Transmit sequencer states
  typedef enum logic [1:0]
  {
    TX_IDLE = 2'b00,
    TX_BYTE = 2'b01,
    TX_WORD = 2'b10,
    TX_EOP = 2'b11
  } tx_state_t;

endpackage

/* File: rtl/spw_pkt_datapath.sv */
// One channel of the packet datapath: FIFOs, byte unpacker and packer,
// loopback, credit limit, rate tick, event flags and the DMA arbiter.
// Assumes a link codec on clk for transmit and a link-clocked receive
// byte bus whose clock is sampled here like any other pin.
`timescale 1ns/1ns
module spw_pkt_datapath
#(
  parameter int DATA_AW = 14,
  parameter int LEN_AW = 10,
  parameter logic [1:0] CHANNEL = 2'h0,
  parameter logic [31:0] REGION_BYTES = 32'h0100_0000
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Link status from the codec
  input wire logic link_connected,
  input wire logic timecode_strobe,
  input wire logic link_error,
  // Transmit characters to the codec
  output logic [7:0] tx_data,
  output logic tx_eop,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic tx_bit_tick,
  // Receive characters, carried by the link clock
  input wire logic rx_link_clk,
  input wire logic [7:0] rx_pin_data,
  input wire logic rx_pin_eop,
  output logic [2:0] rx_credit_tokens,
  // Interrupt, DMA arbitration, memory region
  output logic irq,
  input wire logic [7:0] dma_req,
  output logic [7:0] dma_gnt,
  output logic [31:0] region_base
);

  localparam int DDEPTH = 1 << DATA_AW;
  localparam int LDEPTH = 1 << LEN_AW;

  // Refuse sizes below the almost margins and credit window
  if (DATA_AW < 6 || LEN_AW < 4)
  begin : size_check
    $error("FIFO address widths too small");
  end

  // Whole module state
  typedef struct packed {
    logic [7:0] ctrl_div;
    logic fifo_test;
    logic pkt_dis;
    logic master_en;
    logic [5:0] mask;
    logic [5:0] events;
    logic [31:0] region;
    logic [31:0] rdata;
    logic [DATA_AW:0] tx_wr;
    logic [DATA_AW:0] tx_rd;
    logic [LEN_AW:0] tl_wr;
    logic [LEN_AW:0] tl_rd;
    logic [DATA_AW:0] rx_wr;
    logic [DATA_AW:0] rx_rd;
    logic [LEN_AW:0] rl_wr;
    logic [LEN_AW:0] rl_rd;
    spw_pkt_pkg::tx_state_t txs;
    logic [31:0] word;
    logic [1:0] idx;
    logic [31:0] remain;
    logic [7:0] tx_data;
    logic tx_eop;
    logic tx_valid;
    logic [7:0] div_cnt;
    logic tick;
    logic lk_s1;
    logic lk_s2;
    logic lk_s3;
    logic [8:0] d_s1;
    logic [8:0] d_s2;
    logic [31:0] acc;
    logic [1:0] acc_idx;
    logic [31:0] rx_count;
    logic [2:0] tokens;
    logic [7:0] gnt;
    logic [2:0] last;
  } state_t;

  state_t s;
  state_t next_s;

  // Storage, kept outside the state record
  logic [31:0] tx_mem [DDEPTH];
  logic [31:0] rx_mem [DDEPTH];
  logic [31:0] tl_mem [LDEPTH];
  logic [31:0] rl_mem [LDEPTH];

  // Memory write requests from the next-state logic
  logic tx_push;
  logic tl_push;
  logic rx_push;
  logic rl_push;
  logic [31:0] rx_wdata;
  logic [31:0] rl_wdata;

  // Live FIFO levels and flags
  logic [DATA_AW:0] tx_level;
  logic [DATA_AW:0] rx_level;
  logic [LEN_AW:0] tl_level;
  logic [LEN_AW:0] rl_level;
  logic tx_empty;
  logic tx_full;
  logic tl_empty;
  logic tl_full;
  logic rx_empty;
  logic rx_full;
  logic rl_empty;
  logic rl_full;
  logic tx_aempty;
  logic rx_afull;
  logic [31:0] tx_head;
  logic [31:0] tl_head;
  logic rx_char;
  logic loop_move;

  assign tx_level = s.tx_wr - s.tx_rd;
  assign rx_level = s.rx_wr - s.rx_rd;
  assign tl_level = s.tl_wr - s.tl_rd;
  assign rl_level = s.rl_wr - s.rl_rd;
  assign tx_empty = (tx_level == '0);
  assign tx_full = (tx_level == (DATA_AW + 1)'(DDEPTH));
  assign tl_empty = (tl_level == '0);
  assign tl_full = (tl_level == (LEN_AW + 1)'(LDEPTH));
  assign rx_empty = (rx_level == '0);
  assign rx_full = (rx_level == (DATA_AW + 1)'(DDEPTH));
  assign rl_empty = (rl_level == '0);
  assign rl_full = (rl_level == (LEN_AW + 1)'(LDEPTH));
  assign tx_aempty = (tx_level <= (DATA_AW + 1)'(spw_pkt_pkg::ALMOST_MARGIN));
  assign rx_afull = (rx_level >=
    (DATA_AW + 1)'(DDEPTH - spw_pkt_pkg::ALMOST_MARGIN));
  assign tx_head = tx_mem[s.tx_rd[DATA_AW-1:0]];
  assign tl_head = tl_mem[s.tl_rd[LEN_AW-1:0]];
  // One character per rising link clock edge, while each link clock phase spans at least one clk edge
  assign rx_char = s.lk_s2 && !s.lk_s3;
  // Loopback moves a word only while the transmitter is idle
  assign loop_move = s.fifo_test && s.txs == spw_pkt_pkg::TX_IDLE
    && !tx_empty && !rx_full;

  // Next-state logic for everything the channel keeps
  always_comb
  begin
    logic [5:0] ev;
    logic [DATA_AW:0] free_words;
    logic [LEN_AW:0] free_lens;
    logic [DATA_AW:0] by_data;
    logic [LEN_AW:0] by_len;
    logic [2:0] pick;
    logic found;
    logic [7:0] limit;
    ev = '0;
    free_words = '0;
    free_lens = '0;
    by_data = '0;
    by_len = '0;
    pick = '0;
    found = 1'b0;
    limit = '0;
    next_s = s;
    tx_push = 1'b0;
    tl_push = 1'b0;
    rx_push = 1'b0;
    rl_push = 1'b0;
    rx_wdata = '0;
    rl_wdata = '0;
    next_s.rdata = '0;

    // Register writes
    if (reg_write)
    begin
      unique case (reg_addr)
        spw_pkt_pkg::CTRL_ADDR:
        begin
          // Divisor sets the run rate
          next_s.ctrl_div = reg_wdata[spw_pkt_pkg::CTRL_DIV_LSB +: 8];
          next_s.fifo_test = reg_wdata[spw_pkt_pkg::CTRL_TEST_BIT];
          next_s.pkt_dis = reg_wdata[spw_pkt_pkg::CTRL_PKTDIS_BIT];
          next_s.master_en = reg_wdata[spw_pkt_pkg::CTRL_MASTER_BIT];
        end
        spw_pkt_pkg::MASK_ADDR: next_s.mask = reg_wdata[5:0];
        spw_pkt_pkg::EVENT_ADDR:
          next_s.events = s.events & ~reg_wdata[5:0];
        spw_pkt_pkg::TX_DATA_ADDR:
          // Full FIFO drops the write
          if (!tx_full)
          begin
            tx_push = 1'b1;
            next_s.tx_wr = s.tx_wr + 1'b1;
          end
        spw_pkt_pkg::TX_LEN_ADDR:
          if (!tl_full)
          begin
            tl_push = 1'b1;
            next_s.tl_wr = s.tl_wr + 1'b1;
          end
        spw_pkt_pkg::REGION_ADDR: next_s.region = reg_wdata;
        default: ;
      endcase
    end

    // Register reads, answered in the following cycle
    if (reg_read)
    begin
      unique case (reg_addr)
        spw_pkt_pkg::CTRL_ADDR:
          next_s.rdata = {21'h0, s.master_en, s.pkt_dis, s.fifo_test,
            s.ctrl_div};
        spw_pkt_pkg::MASK_ADDR: next_s.rdata = {26'h0, s.mask};
        // Live flags for polled operation
        spw_pkt_pkg::STATUS_ADDR:
          next_s.rdata = {23'h0, link_connected, rl_empty, rx_afull,
            rx_full, rx_empty, tl_full, tx_aempty, tx_full, tx_empty};
        spw_pkt_pkg::EVENT_ADDR: next_s.rdata = {26'h0, s.events};
        spw_pkt_pkg::RX_DATA_ADDR:
          if (!rx_empty)
          begin
            next_s.rdata = rx_mem[s.rx_rd[DATA_AW-1:0]];
            next_s.rx_rd = s.rx_rd + 1'b1;
          end
        spw_pkt_pkg::RX_LEN_ADDR:
          if (!rl_empty)
          begin
            next_s.rdata = rl_mem[s.rl_rd[LEN_AW-1:0]];
            next_s.rl_rd = s.rl_rd + 1'b1;
          end
        spw_pkt_pkg::REGION_ADDR: next_s.rdata = s.region;
        default: next_s.rdata = '0;
      endcase
    end

    // Test loopback, full word path from the transmit FIFO head
    // into the receive FIFO
    if (loop_move)
    begin
      next_s.tx_rd = s.tx_rd + 1'b1;
      rx_push = 1'b1;
      rx_wdata = tx_head;
    end

    // Transmit sequencer
    unique case (s.txs)
      spw_pkt_pkg::TX_IDLE:
        // Start only on a live link with FIFO test off: data, a length, or both, by mode
        if (!s.fifo_test && link_connected)
        begin
          if (s.pkt_dis && !tx_empty)
          begin
            // Endless packet, no lengths consumed
            next_s.tx_rd = s.tx_rd + 1'b1;
            next_s.word = tx_head;
            next_s.idx = 2'h0;
            next_s.remain = '0;
            next_s.tx_data = tx_head[7:0];
            next_s.tx_valid = 1'b1;
            next_s.txs = spw_pkt_pkg::TX_BYTE;
          end
          else if (!s.pkt_dis && !tl_empty && tl_head == '0)
          begin
            // Empty packet: just the end marker
            next_s.tl_rd = s.tl_rd + 1'b1;
            next_s.tx_eop = 1'b1;
            next_s.tx_valid = 1'b1;
            next_s.txs = spw_pkt_pkg::TX_EOP;
          end
          else if (!s.pkt_dis && !tl_empty && !tx_empty)
          begin
            next_s.tl_rd = s.tl_rd + 1'b1;
            next_s.tx_rd = s.tx_rd + 1'b1;
            next_s.word = tx_head;
            next_s.idx = 2'h0;
            next_s.remain = tl_head;
            next_s.tx_data = tx_head[7:0];
            next_s.tx_valid = 1'b1;
            next_s.txs = spw_pkt_pkg::TX_BYTE;
          end
        end
      spw_pkt_pkg::TX_BYTE:
        if (tx_ready)
        begin
          next_s.remain = s.remain - 1'b1;
          if (!s.pkt_dis && s.remain == 32'h1)
          begin
            // Count reached: unsent lanes of this word are padding
            next_s.tx_eop = 1'b1;
            next_s.txs = spw_pkt_pkg::TX_EOP;
          end
          else if (s.idx == 2'h3)
          begin
            next_s.tx_valid = 1'b0;
            next_s.txs = spw_pkt_pkg::TX_WORD;
          end
          else
          begin
            // Lanes go out low to high
            next_s.idx = s.idx + 1'b1;
            next_s.tx_data = s.word[{s.idx + 1'b1, 3'h0} +: 8];
          end
        end
      spw_pkt_pkg::TX_WORD:
        // Mid-packet the codec simply idles until the next word lands
        // A dropped link parks the packet here until it runs again
        if (!tx_empty && !s.fifo_test && link_connected)
        begin
          next_s.tx_rd = s.tx_rd + 1'b1;
          next_s.word = tx_head;
          next_s.idx = 2'h0;
          next_s.tx_data = tx_head[7:0];
          next_s.tx_valid = 1'b1;
          next_s.txs = spw_pkt_pkg::TX_BYTE;
        end
      spw_pkt_pkg::TX_EOP:
        if (tx_ready)
        begin
          // Next packet opens on a fresh word
          next_s.tx_eop = 1'b0;
          next_s.tx_valid = 1'b0;
          ev[spw_pkt_pkg::EV_PKT_SENT] = 1'b1;
          next_s.txs = spw_pkt_pkg::TX_IDLE;
        end
    endcase

    // Bit rate tick: fixed connect rate until the link runs
    if (!link_connected)
      limit = spw_pkt_pkg::CONNECT_DIV;
    else if (s.ctrl_div == 8'h00)
      limit = 8'h01;
    else
      limit = s.ctrl_div;
    next_s.tick = (s.div_cnt >= limit - 8'h01);
    next_s.div_cnt = next_s.tick ? 8'h00 : s.div_cnt + 8'h01;

    // Receive pin synchroniser and packer
    next_s.lk_s1 = rx_link_clk;
    next_s.lk_s2 = s.lk_s1;
    next_s.lk_s3 = s.lk_s2;
    next_s.d_s1 = {rx_pin_eop, rx_pin_data};
    next_s.d_s2 = s.d_s1;
    if (rx_char && !s.fifo_test)
    begin
      if (!s.d_s2[8])
      begin
        // Arrival order fills lanes low to high
        next_s.acc[{s.acc_idx, 3'h0} +: 8] = s.d_s2[7:0];
        next_s.acc_idx = s.acc_idx + 1'b1;
        next_s.rx_count = s.rx_count + 32'h1;
        if (s.acc_idx == 2'h3 && !rx_full)
        begin
          rx_push = 1'b1;
          rx_wdata = next_s.acc;
          next_s.acc = '0;
        end
      end
      else
      begin
        // Upper lanes already cleared, so the push is zero padded
        if (s.acc_idx != 2'h0 && !rx_full)
        begin
          rx_push = 1'b1;
          rx_wdata = s.acc;
        end
        // Exact byte count recorded per packet
        if (!rl_full)
        begin
          rl_push = 1'b1;
          rl_wdata = s.rx_count;
        end
        next_s.acc = '0;
        next_s.acc_idx = 2'h0;
        next_s.rx_count = '0;
        ev[spw_pkt_pkg::EV_PKT_RCVD] = 1'b1;
      end
    end
    if (rx_push)
      next_s.rx_wr = s.rx_wr + 1'b1;
    if (rl_push)
      next_s.rl_wr = s.rl_wr + 1'b1;

    // Credit follows free space in both receive FIFOs
    // One word is held back for the packer's partial word.
    free_words = (DATA_AW + 1)'(DDEPTH) - rx_level - 1'b1;
    free_lens = (LEN_AW + 1)'(LDEPTH) - rl_level;
    by_data = free_words >> 1;
    by_len = free_lens >> 3;
    next_s.tokens = spw_pkt_pkg::MAX_TOKENS;
    if (by_data < (DATA_AW + 1)'(next_s.tokens))
      next_s.tokens = 3'(by_data);
    if (by_len < (LEN_AW + 1)'(next_s.tokens))
      next_s.tokens = 3'(by_len);

    // Sticky events; a new event beats a same-cycle clear
    ev[spw_pkt_pkg::EV_TX_AEMPTY] = tx_aempty;
    ev[spw_pkt_pkg::EV_RX_AFULL] = rx_afull;
    ev[spw_pkt_pkg::EV_TIMECODE] = timecode_strobe;
    ev[spw_pkt_pkg::EV_ERROR] = link_error;
    next_s.events = next_s.events | ev;

    // Round robin; owner keeps the bus until it drops request
    if ((s.gnt & dma_req) == 8'h00)
    begin
      next_s.gnt = 8'h00;
      for (int i = 1; i <= 8; i++)
      begin
        pick = s.last + 3'(i);
        if (!found && dma_req[pick])
        begin
          found = 1'b1;
          next_s.gnt[pick] = 1'b1;
          next_s.last = pick;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s <= '0;
      s.ctrl_div <= spw_pkt_pkg::CTRL_DIV_RESET;
      s.region <= 32'(CHANNEL) * REGION_BYTES;
      s.last <= 3'h7;
    end
    else
      s <= next_s;
  end

  // Memory writes, no reset needed on storage
  always_ff @(posedge clk)
  begin
    if (tx_push)
      tx_mem[s.tx_wr[DATA_AW-1:0]] <= reg_wdata;
    if (tl_push)
      tl_mem[s.tl_wr[LEN_AW-1:0]] <= reg_wdata;
    if (rx_push)
      rx_mem[s.rx_wr[DATA_AW-1:0]] <= rx_wdata;
    if (rl_push)
      rl_mem[s.rl_wr[LEN_AW-1:0]] <= rl_wdata;
  end

  // Outputs
  assign reg_rdata = s.rdata;
  assign tx_data = s.tx_data;
  assign tx_eop = s.tx_eop;
  assign tx_valid = s.tx_valid;
  assign tx_bit_tick = s.tick;
  assign rx_credit_tokens = s.tokens;
  assign dma_gnt = s.gnt;
  assign region_base = s.region;
  // Master enable gates every masked source at once
  assign irq = s.master_en && |(s.events & s.mask);

  chk_tx_drop_full: assert property (@(posedge clk) disable iff (!reset_n)
    reg_write && reg_addr == spw_pkt_pkg::TX_DATA_ADDR && tx_full
    |=> s.tx_wr == $past(s.tx_wr))
    else $error("write to full transmit FIFO was stored");

  chk_tx_low_first: assert property (@(posedge clk) disable iff (!reset_n)
    s.txs == spw_pkt_pkg::TX_WORD && !tx_empty && !s.fifo_test
    && link_connected
    |=> tx_valid && tx_data == $past(tx_head[7:0]))
    else $error("new word did not start with its low byte");

  chk_tx_end_count: assert property (@(posedge clk) disable iff (!reset_n)
    s.txs == spw_pkt_pkg::TX_BYTE && tx_ready && !s.pkt_dis
    && s.remain == 32'h1 |=> tx_eop && tx_valid
    ##1 (tx_eop == !$past(tx_ready)))
    else $error("end marker not sent when count ran out");

  chk_rx_pad_zero: assert property (@(posedge clk) disable iff (!reset_n)
    rx_char && !s.fifo_test && s.d_s2[8] && s.acc_idx == 2'h1 && !rx_full
    |-> rx_push && rx_wdata[31:8] == 24'h0)
    else $error("partial word not zero padded");

  chk_rx_len_push: assert property (@(posedge clk) disable iff (!reset_n)
    rx_char && !s.fifo_test && s.d_s2[8] && !rl_full
    |=> s.rl_wr == $past(s.rl_wr) + 1'b1 && s.rx_count == 32'h0)
    else $error("packet length not recorded");

  chk_loop_route: assert property (@(posedge clk) disable iff (!reset_n)
    loop_move |-> rx_wdata == tx_head ##1 s.tx_rd == $past(s.tx_rd) + 1'b1)
    else $error("loopback word not moved");

  chk_credit_full: assert property (@(posedge clk) disable iff (!reset_n)
    rx_level >= (DATA_AW + 1)'(DDEPTH - 2) |=> rx_credit_tokens == 3'h0)
    else $error("credit granted with receive FIFO nearly full");

  chk_irq_master: assert property (@(posedge clk) disable iff (!reset_n)
    !s.master_en |-> !irq)
    else $error("interrupt with master enable clear");

  chk_connect_rate: assert property (@(posedge clk)
    disable iff (!reset_n || link_connected)
    s.tick |=> (!s.tick)[*8])
    else $error("connect rate tick too fast");

  chk_arb_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (dma_gnt & dma_req) != 8'h00 |=> dma_gnt == $past(dma_gnt)
    && $onehot0(dma_gnt))
    else $error("arbiter took the bus from an active owner");

endmodule

/* File: tb/remote_node.sv */
// Far-end link node: grants transmit credit and sends characters.
// Assumes the datapath clock; receive characters use a 48 ns clock.
`timescale 1ns/1ns
module remote_node
(
  // Clock and bench control
  input wire logic clk,
  input wire logic stall,
  // Characters from the datapath
  input wire logic [7:0] tx_data,
  input wire logic tx_eop,
  input wire logic tx_valid,
  output logic tx_ready,
  // Characters towards the datapath
  output logic rx_link_clk,
  output logic [7:0] rx_pin_data,
  output logic rx_pin_eop
);
  // Characters taken, end flag above the byte
  logic [8:0] got[$];

  // Idle link, no credit until the first edge
  initial
  begin
    tx_ready = 1'b0;
    rx_link_clk = 1'b0;
    rx_pin_data = 8'h00;
    rx_pin_eop = 1'b0;
  end

  // Credit withheld while stalled; changes only after an edge
  always @(posedge clk)
  begin
    tx_ready <= !stall;
    if (tx_valid && tx_ready)
      got.push_back({tx_eop, tx_data});
  end

  // One character; the clock moves only inside the frame
  task automatic send(input logic eop, input logic [7:0] b);
  begin
    rx_pin_data = b;
    rx_pin_eop = eop;
    #12 rx_link_clk = 1'b1;
    #24 rx_link_clk = 1'b0;
    // Hold over, so stale values must not look valid
    #12 rx_pin_data = ~b;
    rx_pin_eop = ~eop;
  end
  endtask
endmodule

/* File: tb/spw_pkt_datapath_test.sv */
// Self-checking bench for one channel packet datapath.
// Assumes the remote node model and small FIFO depths (64 and 16).
`timescale 1ns/1ns
module spw_pkt_datapath_test;
  // Design connections
  logic clk, reset_n, reg_write, reg_read, link_connected;
  logic timecode_strobe, link_error, tx_eop, tx_valid, tx_ready;
  logic tx_bit_tick, rx_link_clk, rx_pin_eop, irq, stall;
  logic [7:0] reg_addr, tx_data, rx_pin_data, dma_req, dma_gnt;
  logic [31:0] reg_wdata, reg_rdata, region_base, rd_val;
  logic [2:0] rx_credit_tokens;
  // Bookkeeping
  int failures, check_count, gap, i;
  logic [8:0] exp_tx[11] = '{9'h011, 9'h022, 9'h033, 9'h044, 9'h055,
    9'h066, 9'h077, 9'h100, 9'h0DD, 9'h0CC, 9'h100};

  spw_pkt_datapath #(.DATA_AW(6), .LEN_AW(4)) dut (.clk(clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .link_connected(link_connected), .timecode_strobe(timecode_strobe),
    .link_error(link_error), .tx_data(tx_data), .tx_eop(tx_eop),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_bit_tick(tx_bit_tick),
    .rx_link_clk(rx_link_clk), .rx_pin_data(rx_pin_data),
    .rx_pin_eop(rx_pin_eop), .rx_credit_tokens(rx_credit_tokens),
    .irq(irq), .dma_req(dma_req), .dma_gnt(dma_gnt),
    .region_base(region_base));
  remote_node u_node (.clk(clk), .stall(stall), .tx_data(tx_data),
    .tx_eop(tx_eop), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_link_clk(rx_link_clk), .rx_pin_data(rx_pin_data),
    .rx_pin_eop(rx_pin_eop));

  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Counts, verdict and end of run
  task automatic results;
  begin
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  task automatic hang;
  begin
    failures++;
    results();
  end
  endtask
  task automatic check(input string name, input logic [31:0] exp,
    input logic [31:0] got);
  begin
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  end
  endtask
  // One edge, then let its updates settle
  task automatic step;
  begin
    @(posedge clk);
    #1;
  end
  endtask
  // Register write: one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  end
  endtask
  // Register read: data only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  end
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a,
    input logic [31:0] e);
  begin
    rd(a, rd_val);
    check(n, e, rd_val);
  end
  endtask
  // Cycles between two bit-rate ticks
  task automatic tick_gap(output int n);
  begin
    for (n = 0; n < 300 && tx_bit_tick !== 1'b1; n++)
      step();
    if (n >= 300)
      hang();
    step();
    for (n = 1; n < 300 && tx_bit_tick !== 1'b1; n++)
      step();
    if (n >= 300)
      hang();
  end
  endtask
  // Bounded wait for characters at the far end
  task automatic wait_q(input int n);
  begin
    for (i = 0; i < 3000 && u_node.got.size() < n; i++)
      step();
    if (i >= 3000)
      hang();
  end
  endtask

  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    {reg_write, reg_read, link_connected, timecode_strobe} = 4'h0;
    {link_error, stall, reg_addr, dma_req} = 18'h0;
    reg_wdata = 32'h0;
    failures = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) step();
    check("credit", 32'h2, 32'(rx_credit_tokens));
    rd_chk("ctrl", spw_pkt_pkg::CTRL_ADDR, 32'h19);
    rd_chk("status", spw_pkt_pkg::STATUS_ADDR, 32'h95);
    rd_chk("unmapped", 8'h40, 32'h0);
    check("region reset", 32'h0, region_base);
    wr(spw_pkt_pkg::REGION_ADDR, 32'h0200_0000);
    rd_chk("region", spw_pkt_pkg::REGION_ADDR, 32'h0200_0000);
    check("region pin", 32'h0200_0000, region_base);
    tick_gap(gap);
    check("connect gap", 32'd25, 32'(gap));
    link_connected <= 1'b1;
    wr(spw_pkt_pkg::CTRL_ADDR, 32'h4);
    tick_gap(gap);
    check("run gap", 32'd4, 32'(gap));
    // Two packets, seven then two bytes, with a stall at the start
    stall <= 1'b1;
    wr(spw_pkt_pkg::TX_DATA_ADDR, 32'h44332211);
    wr(spw_pkt_pkg::TX_DATA_ADDR, 32'h88776655);
    wr(spw_pkt_pkg::TX_DATA_ADDR, 32'h0000CCDD);
    wr(spw_pkt_pkg::TX_LEN_ADDR, 32'h7);
    wr(spw_pkt_pkg::TX_LEN_ADDR, 32'h2);
    repeat (20) step();
    check("stalled", 32'h0, 32'(u_node.got.size()));
    stall <= 1'b0;
    wait_q(11);
    for (int k = 0; k < 11; k++)
      check("tx char", 32'(exp_tx[k] & (exp_tx[k][8] ? 9'h100 : 9'h1FF)),
        32'(u_node.got[k] & (exp_tx[k][8] ? 9'h100 : 9'h1FF)));
    rd(spw_pkt_pkg::EVENT_ADDR, rd_val);
    check("sent event", 32'h1, 32'(rd_val[2]));
    // Receive five bytes and an end marker
    foreach (exp_tx[k])
      if (k < 5)
        u_node.send(1'b0, exp_tx[k][7:0]);
    u_node.send(1'b1, 8'h00);
    repeat (8) step();
    rd_chk("rx word", spw_pkt_pkg::RX_DATA_ADDR, 32'h44332211);
    rd_chk("rx pad", spw_pkt_pkg::RX_DATA_ADDR, 32'h00000055);
    rd_chk("rx len", spw_pkt_pkg::RX_LEN_ADDR, 32'h5);
    // Interrupt gating: source mask and master enable
    wr(spw_pkt_pkg::MASK_ADDR, 32'h08);
    repeat (2) step();
    check("irq master off", 32'h0, 32'(irq));
    wr(spw_pkt_pkg::CTRL_ADDR, 32'h404);
    repeat (2) step();
    check("irq received", 32'h1, 32'(irq));
    wr(spw_pkt_pkg::MASK_ADDR, 32'h10);
    wr(spw_pkt_pkg::EVENT_ADDR, 32'h3F);
    repeat (2) step();
    check("irq masked", 32'h0, 32'(irq));
    rd(spw_pkt_pkg::EVENT_ADDR, rd_val);
    check("event clear", 32'h0, 32'(rd_val[3:2]));
    timecode_strobe <= 1'b1;
    @(posedge clk);
    timecode_strobe <= 1'b0;
    repeat (3) step();
    check("irq timecode", 32'h1, 32'(irq));
    // Error pulse must leave a sticky event
    link_error <= 1'b1;
    @(posedge clk);
    link_error <= 1'b0;
    rd(spw_pkt_pkg::EVENT_ADDR, rd_val);
    check("error event", 32'h1, 32'(rd_val[5]));
    // FIFO test path: word comes back whole
    wr(spw_pkt_pkg::CTRL_ADDR, 32'h104);
    wr(spw_pkt_pkg::TX_DATA_ADDR, 32'hA55AC33C);
    for (i = 0; i < 50; i++)
    begin
      rd(spw_pkt_pkg::STATUS_ADDR, rd_val);
      if (rd_val[4] === 1'b0)
        break;
    end
    if (i >= 50)
      hang();
    rd_chk("loop word", spw_pkt_pkg::RX_DATA_ADDR, 32'hA55AC33C);
    // Packet disable: bytes leave without any length
    u_node.got.delete();
    wr(spw_pkt_pkg::CTRL_ADDR, 32'h204);
    wr(spw_pkt_pkg::TX_DATA_ADDR, 32'h0D0C0B0A);
    wait_q(4);
    for (int k = 0; k < 4; k++)
      check("raw char", 32'h0A + k, 32'(u_node.got[k]));
    // Fill the receive FIFO to 62 words: credit must run out
    for (int k = 0; k < 248; k++)
      u_node.send(1'b0, 8'(k));
    repeat (2) step();
    check("credit full", 32'h0, 32'(rx_credit_tokens));
    // Arbiter: grant follows the requester, then moves on
    dma_req <= 8'h05;
    repeat (2) step();
    check("grant first", 32'h01, 32'(dma_gnt));
    dma_req <= 8'h04;
    repeat (2) step();
    check("grant next", 32'h04, 32'(dma_gnt));
    // Overfill the transmit FIFO with the link down
    link_connected <= 1'b0;
    wr(spw_pkt_pkg::CTRL_ADDR, 32'h4);
    repeat (65) wr(spw_pkt_pkg::TX_DATA_ADDR, 32'h5A5A5A5A);
    rd(spw_pkt_pkg::STATUS_ADDR, rd_val);
    check("tx full", 32'h2, 32'(rd_val[1:0]));
    results();
  end
endmodule
